//--- adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFS_CONTROL_A 5'h00
`define OFS_CONTROL_B 5'h01
`define OFS_CONTROL_C 5'h02
`define OFS_CONTROL_D 5'h03
`define OFS_CONTROL_E 5'h04
`define OFS_SAMPLE_LENGTH_CTRL 5'h05
`define OFS_POSITIVE_INPUT_SELECT 5'h06
`define OFS_COMMAND 5'h08
`define OFS_EVENT_CONTROL 5'h09
`define OFS_INTERRUPT_ENABLE 5'h0A
`define OFS_INTERRUPT_FLAGS 5'h0B
`define OFS_DEBUG_CONTROL 5'h0C
`define OFS_BYTE_SCRATCH 5'h0D
`define OFS_RESULT_LO 5'h10
`define OFS_RESULT_HI 5'h11
`define OFS_WIN_LOW_LO 5'h12
`define OFS_WIN_LOW_HI 5'h13
`define OFS_WIN_HIGH_LO 5'h14
`define OFS_WIN_HIGH_HI 5'h15
`define OFS_CALIBRATION 5'h16
`define OFS_CONVERTER_STATUS 5'h18

// ---------------------------------------------------------------
// Writable bits of each register
// ---------------------------------------------------------------
`define WMASK_CONTROL_A 8'h87
`define WMASK_CONTROL_B 8'h07
`define WMASK_CONTROL_C 8'h77
`define WMASK_CONTROL_D 8'hFF
`define WMASK_CONTROL_E 8'h07
`define WMASK_SAMPLE_LENGTH 8'h1F
`define WMASK_INPUT_SELECT 8'h1F
`define WMASK_EVENT_CONTROL 8'h01
`define WMASK_INTERRUPT 8'h03
`define WMASK_DEBUG_CONTROL 8'h01
`define WMASK_CALIBRATION 8'h01

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_ENABLE 0
`define BIT_CONTINUOUS 1
`define BIT_RESOLUTION 2
`define BIT_RUN_IN_STANDBY 7
`define BIT_START_CONVERSION 0
`define BIT_START_ON_EVENT 0
`define BIT_RESULT_READY 0
`define BIT_WINDOW_COMPARE 1
`define BIT_RUN_WHEN_HALTED 0
`define FLD_DIVIDER_HI 2
`define FLD_DIVIDER_LO 0
`define FLD_INIT_DELAY_HI 7
`define FLD_INIT_DELAY_LO 5
`define FLD_WIN_MODE_HI 2
`define FLD_WIN_MODE_LO 0
`define FLD_SAMPLE_LEN_HI 4
`define FLD_SAMPLE_LEN_LO 0

// ---------------------------------------------------------------
// Reset values, vectors and timing
// ---------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define VECTOR_RESULT_READY 8'h00
`define VECTOR_WINDOW_COMPARE 8'h02
`define CONV_BASE_CYCLES 9'h00D
`define WIN_MODE_NONE 3'h0
`define WIN_MODE_BELOW 3'h1
`define WIN_MODE_ABOVE 3'h2
`define WIN_MODE_INSIDE 3'h3
`define WIN_MODE_OUTSIDE 3'h4

`endif

//--- adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Sleep state from the sleep controller
  typedef enum logic [1:0] {
    SLEEP_ACTIVE,
    SLEEP_IDLE,
    SLEEP_STANDBY,
    SLEEP_POWER_DOWN
  } sleep_mode_e;

  // Conversion sequencer
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_DELAY,
    CONV_RUN
  } conv_state_e;

endpackage : adc_ctrl_pkg

//--- sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sync_2ff

//--- adc_trigger_irq_sleep_ctrl.sv
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
// Overview of operation
// - Event starts conversion only if enabled
// - Result ready uses vector 0x00
// - Window compare uses vector 0x02, mode-selected
// - Flags set regardless of enable bits
// - Each source has its own enable
// - Request while flag and enable set
// - Converter off in standby by default
// - Run-in-standby keeps converter running, initial delay on every start
// - Clock requested only while start bit set or conversion in progress
// - Event rising edge sets start bit
// - Completion sets flag, clears start bit
// - Power-down freezes, no new starts
// - Frozen conversion finishes, result invalid
// - Free-running restarts two cycles after completion
// - Initial delay codes 0..5 select cycles
module adc_trigger_irq_sleep_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire adc_ctrl_pkg::reg_req_s reg_req,
  output logic [7:0] rd_data,
  input wire adc_ctrl_pkg::sleep_mode_e sleep_mode,
  input wire logic dbg_halt,
  input wire logic start_event,
  input wire logic [9:0] sample_value,
  output logic sample_strobe,
  output logic clk_request,
  output logic irq_result_ready,
  output logic irq_window_compare,
  output logic irq,
  output logic [7:0] irq_vector
);
  import adc_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] control_a_q;
  logic [7:0] control_b_q;
  logic [7:0] control_c_q;
  logic [7:0] control_d_q;
  logic [7:0] control_e_q;
  logic [7:0] sample_length_ctrl_q;
  logic [7:0] positive_input_select_q;
  logic [7:0] event_control_q;
  logic [7:0] interrupt_enable_q;
  logic [7:0] debug_control_q;
  logic [7:0] byte_scratch_q;
  logic [7:0] calibration_q;
  logic [15:0] window_low_threshold_q;
  logic [15:0] window_high_threshold_q;
  logic [15:0] conversion_result_q;
  logic [1:0] interrupt_flag_bits_q;
  logic [1:0] interrupt_flag_bits_d;
  logic start_conversion_bit_q;
  logic result_invalid_q;

  conv_state_e state_q;
  logic [8:0] count_q;
  logic [7:0] divider_q;
  logic init_pending_q;
  logic frozen_seen_q;
  logic restart_q;
  logic event_prev_q;

  logic event_sync;
  logic event_rise;
  logic wr_en;
  logic frozen;
  logic enabled;
  logic adc_tick;
  logic conv_done;
  logic start_now;
  logic window_hit;
  logic [7:0] divider_mask;
  logic [8:0] init_cycles;
  logic [8:0] conv_cycles;
  logic [15:0] result_d;
  logic [7:0] rd_mux;

  assign wr_en = reg_req.wr;

  // ---------------------------------------------------------------
  // Event input
  // ---------------------------------------------------------------
  sync_2ff u_event_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d(start_event),
    .q(event_sync)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_prev_q <= 1'b0;
    end else begin
      event_prev_q <= event_sync;
    end
  end

  assign event_rise = event_sync & ~event_prev_q;

  // ---------------------------------------------------------------
  // Sleep and enable qualification
  // ---------------------------------------------------------------
  assign frozen = (sleep_mode == SLEEP_POWER_DOWN) ||
                  (dbg_halt && !debug_control_q[`BIT_RUN_WHEN_HALTED]);
  assign enabled = control_a_q[`BIT_ENABLE] &&
                   !((sleep_mode == SLEEP_STANDBY) &&
                     !control_a_q[`BIT_RUN_IN_STANDBY]);

  // ---------------------------------------------------------------
  // Converter clock prescaler
  // ---------------------------------------------------------------
  assign divider_mask = 8'((9'h002 << control_c_q[`FLD_DIVIDER_HI:
                                                 `FLD_DIVIDER_LO]) - 9'h001);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      divider_q <= 8'h00;
    end else if (!enabled || frozen) begin
      divider_q <= enabled ? divider_q : 8'h00;
    end else if (adc_tick) begin
      divider_q <= 8'h00;
    end else begin
      divider_q <= divider_q + 8'h01;
    end
  end

  assign adc_tick = enabled && !frozen &&
                    ((divider_q & divider_mask) == divider_mask);

  // ---------------------------------------------------------------
  // Delay and conversion lengths
  // ---------------------------------------------------------------
  always_comb begin
    case (control_d_q[`FLD_INIT_DELAY_HI:`FLD_INIT_DELAY_LO])
      3'h0: init_cycles = 9'h000;
      3'h1: init_cycles = 9'h010;
      3'h2: init_cycles = 9'h020;
      3'h3: init_cycles = 9'h040;
      3'h4: init_cycles = 9'h080;
      3'h5: init_cycles = 9'h100;
      default: init_cycles = 9'h000;
    endcase
  end

  assign conv_cycles = `CONV_BASE_CYCLES +
    {4'h0, sample_length_ctrl_q[`FLD_SAMPLE_LEN_HI:`FLD_SAMPLE_LEN_LO]};

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  assign start_now = (state_q == CONV_IDLE) && enabled && !frozen &&
                     start_conversion_bit_q;
  assign conv_done = (state_q == CONV_RUN) && adc_tick &&
                     (count_q == 9'h001);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CONV_IDLE;
      count_q <= 9'h000;
    end else if (!enabled) begin
      state_q <= CONV_IDLE;
      count_q <= 9'h000;
    end else begin
      case (state_q)
        CONV_IDLE: begin
          if (start_now && init_pending_q && (init_cycles != 9'h000)) begin
            state_q <= CONV_DELAY;
            count_q <= init_cycles;
          end else if (start_now) begin
            state_q <= CONV_RUN;
            count_q <= conv_cycles;
          end
        end
        CONV_DELAY: begin
          if (adc_tick && (count_q == 9'h001)) begin
            state_q <= CONV_RUN;
            count_q <= conv_cycles;
          end else if (adc_tick) begin
            count_q <= count_q - 9'h001;
          end
        end
        CONV_RUN: begin
          if (conv_done) begin
            state_q <= CONV_IDLE;
            count_q <= 9'h000;
          end else if (adc_tick) begin
            count_q <= count_q - 9'h001;
          end
        end
        default: begin
          state_q <= CONV_IDLE;
          count_q <= 9'h000;
        end
      endcase
    end
  end

  // Initial delay is owed after enable, standby or power-down
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      init_pending_q <= 1'b1;
    end else if (!control_a_q[`BIT_ENABLE] ||
                 (sleep_mode == SLEEP_STANDBY) ||
                 (sleep_mode == SLEEP_POWER_DOWN)) begin
      init_pending_q <= 1'b1;
    end else if (state_q == CONV_RUN) begin
      init_pending_q <= 1'b0;
    end
  end

  // Start of sampling to the analog front end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= enabled && !frozen &&
                       ((start_now && !(init_pending_q &&
                         (init_cycles != 9'h000))) ||
                        ((state_q == CONV_DELAY) && adc_tick &&
                         (count_q == 9'h001)));
    end
  end

  // ---------------------------------------------------------------
  // Start bit and free-running restart
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= conv_done && control_a_q[`BIT_CONTINUOUS];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      start_conversion_bit_q <= 1'b0;
    end else if (!enabled) begin
      start_conversion_bit_q <= 1'b0;
    end else if (conv_done) begin
      start_conversion_bit_q <= 1'b0;
    end else if (restart_q) begin
      start_conversion_bit_q <= 1'b1;
    end else if (wr_en && (reg_req.addr == `OFS_COMMAND) &&
                 reg_req.wdata[`BIT_START_CONVERSION]) begin
      start_conversion_bit_q <= 1'b1;
    end else if (event_rise && (state_q == CONV_IDLE) &&
                 event_control_q[`BIT_START_ON_EVENT]) begin
      start_conversion_bit_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Result, freeze tracking and window compare
  // ---------------------------------------------------------------
  assign result_d = control_a_q[`BIT_RESOLUTION] ?
                    {8'h00, sample_value[9:2]} : {6'h00, sample_value};

  always_comb begin
    case (control_e_q[`FLD_WIN_MODE_HI:`FLD_WIN_MODE_LO])
      `WIN_MODE_BELOW: window_hit = result_d < window_low_threshold_q;
      `WIN_MODE_ABOVE: window_hit = result_d > window_high_threshold_q;
      `WIN_MODE_INSIDE: window_hit = (result_d > window_low_threshold_q) &&
                                     (result_d < window_high_threshold_q);
      `WIN_MODE_OUTSIDE: window_hit = (result_d < window_low_threshold_q) ||
                                      (result_d > window_high_threshold_q);
      default: window_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conversion_result_q <= `RESET_WORD;
    end else if (conv_done) begin
      conversion_result_q <= result_d;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frozen_seen_q <= 1'b0;
      result_invalid_q <= 1'b0;
    end else if (conv_done) begin
      frozen_seen_q <= 1'b0;
      result_invalid_q <= frozen_seen_q;
    end else if (state_q == CONV_IDLE) begin
      frozen_seen_q <= 1'b0;
    end else if (frozen) begin
      frozen_seen_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags and requests
  // ---------------------------------------------------------------
  always_comb begin
    interrupt_flag_bits_d = interrupt_flag_bits_q;
    if (wr_en && (reg_req.addr == `OFS_INTERRUPT_FLAGS)) begin
      interrupt_flag_bits_d = interrupt_flag_bits_q &
                              ~reg_req.wdata[1:0];
    end
    if (conv_done) begin
      interrupt_flag_bits_d[`BIT_RESULT_READY] = 1'b1;
    end
    if (conv_done && window_hit) begin
      interrupt_flag_bits_d[`BIT_WINDOW_COMPARE] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_flag_bits_q <= 2'h0;
    end else begin
      interrupt_flag_bits_q <= interrupt_flag_bits_d;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_result_ready <= 1'b0;
      irq_window_compare <= 1'b0;
      irq <= 1'b0;
      irq_vector <= `VECTOR_RESULT_READY;
    end else begin
      irq_result_ready <= interrupt_flag_bits_d[`BIT_RESULT_READY] &&
                          interrupt_enable_q[`BIT_RESULT_READY];
      irq_window_compare <= interrupt_flag_bits_d[`BIT_WINDOW_COMPARE] &&
                            interrupt_enable_q[`BIT_WINDOW_COMPARE];
      irq <= |(interrupt_flag_bits_d & interrupt_enable_q[1:0]);
      if (interrupt_flag_bits_d[`BIT_RESULT_READY] &&
          interrupt_enable_q[`BIT_RESULT_READY]) begin
        irq_vector <= `VECTOR_RESULT_READY;
      end else if (interrupt_flag_bits_d[`BIT_WINDOW_COMPARE] &&
                   interrupt_enable_q[`BIT_WINDOW_COMPARE]) begin
        irq_vector <= `VECTOR_WINDOW_COMPARE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Peripheral clock request
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_request <= 1'b0;
    end else begin
      clk_request <= enabled && !conv_done &&
                     ((state_q != CONV_IDLE) || start_conversion_bit_q);
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      control_a_q <= `RESET_BYTE;
      control_b_q <= `RESET_BYTE;
      control_c_q <= `RESET_BYTE;
      control_d_q <= `RESET_BYTE;
      control_e_q <= `RESET_BYTE;
      sample_length_ctrl_q <= `RESET_BYTE;
      positive_input_select_q <= `RESET_BYTE;
      event_control_q <= `RESET_BYTE;
      interrupt_enable_q <= `RESET_BYTE;
      debug_control_q <= `RESET_BYTE;
      byte_scratch_q <= `RESET_BYTE;
      calibration_q <= `RESET_BYTE;
      window_low_threshold_q <= `RESET_WORD;
      window_high_threshold_q <= `RESET_WORD;
    end else if (wr_en) begin
      case (reg_req.addr)
        `OFS_CONTROL_A: control_a_q <= reg_req.wdata & `WMASK_CONTROL_A;
        `OFS_CONTROL_B: control_b_q <= reg_req.wdata & `WMASK_CONTROL_B;
        `OFS_CONTROL_C: control_c_q <= reg_req.wdata & `WMASK_CONTROL_C;
        `OFS_CONTROL_D: control_d_q <= reg_req.wdata & `WMASK_CONTROL_D;
        `OFS_CONTROL_E: control_e_q <= reg_req.wdata & `WMASK_CONTROL_E;
        `OFS_SAMPLE_LENGTH_CTRL:
          sample_length_ctrl_q <= reg_req.wdata & `WMASK_SAMPLE_LENGTH;
        `OFS_POSITIVE_INPUT_SELECT:
          positive_input_select_q <= reg_req.wdata & `WMASK_INPUT_SELECT;
        `OFS_EVENT_CONTROL:
          event_control_q <= reg_req.wdata & `WMASK_EVENT_CONTROL;
        `OFS_INTERRUPT_ENABLE:
          interrupt_enable_q <= reg_req.wdata & `WMASK_INTERRUPT;
        `OFS_DEBUG_CONTROL:
          debug_control_q <= reg_req.wdata & `WMASK_DEBUG_CONTROL;
        `OFS_BYTE_SCRATCH: byte_scratch_q <= reg_req.wdata;
        `OFS_CALIBRATION:
          calibration_q <= reg_req.wdata & `WMASK_CALIBRATION;
        `OFS_WIN_LOW_LO: window_low_threshold_q[7:0] <= reg_req.wdata;
        `OFS_WIN_LOW_HI: window_low_threshold_q[15:8] <= reg_req.wdata;
        `OFS_WIN_HIGH_LO: window_high_threshold_q[7:0] <= reg_req.wdata;
        `OFS_WIN_HIGH_HI: window_high_threshold_q[15:8] <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always_comb begin
    case (reg_req.addr)
      `OFS_CONTROL_A: rd_mux = control_a_q;
      `OFS_CONTROL_B: rd_mux = control_b_q;
      `OFS_CONTROL_C: rd_mux = control_c_q;
      `OFS_CONTROL_D: rd_mux = control_d_q;
      `OFS_CONTROL_E: rd_mux = control_e_q;
      `OFS_SAMPLE_LENGTH_CTRL: rd_mux = sample_length_ctrl_q;
      `OFS_POSITIVE_INPUT_SELECT: rd_mux = positive_input_select_q;
      `OFS_COMMAND: rd_mux = {7'h00, start_conversion_bit_q};
      `OFS_EVENT_CONTROL: rd_mux = event_control_q;
      `OFS_INTERRUPT_ENABLE: rd_mux = interrupt_enable_q;
      `OFS_INTERRUPT_FLAGS: rd_mux = {6'h00, interrupt_flag_bits_q};
      `OFS_DEBUG_CONTROL: rd_mux = debug_control_q;
      `OFS_BYTE_SCRATCH: rd_mux = byte_scratch_q;
      `OFS_RESULT_LO: rd_mux = conversion_result_q[7:0];
      `OFS_RESULT_HI: rd_mux = conversion_result_q[15:8];
      `OFS_WIN_LOW_LO: rd_mux = window_low_threshold_q[7:0];
      `OFS_WIN_LOW_HI: rd_mux = window_low_threshold_q[15:8];
      `OFS_WIN_HIGH_LO: rd_mux = window_high_threshold_q[7:0];
      `OFS_WIN_HIGH_HI: rd_mux = window_high_threshold_q[15:8];
      `OFS_CALIBRATION: rd_mux = calibration_q;
      `OFS_CONVERTER_STATUS: rd_mux = {4'h0, clk_request, init_pending_q,
                                       (state_q != CONV_IDLE),
                                       result_invalid_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else if (reg_req.rd) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule : adc_trigger_irq_sleep_ctrl

//--- adc_evt_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Event source and interrupt observer
// ----------------------------------------
module adc_evt_src (
  input wire logic clk_sys,
  input wire logic irq,
  output logic start_event,
  output logic [9:0] sample_value,
  output int n_irq
);
  logic irq_d;
  initial begin
    start_event = 1'b0;
    sample_value = 10'h3FF;
    n_irq = 0;
    irq_d = 1'b0;
  end
  // Counts taken interrupts
  always @(posedge clk_sys) begin
    irq_d <= irq;
    if (irq && !irq_d) n_irq <= n_irq + 1;
  end
  // Level held long enough for the synchroniser
  task automatic pulse;
    @(posedge clk_sys);
    start_event <= 1'b1;
    repeat (4) @(posedge clk_sys);
    start_event <= 1'b0;
  endtask : pulse
endmodule : adc_evt_src

//--- adc_ctrl_chk.sv
`timescale 1ns/1ps
module adc_ctrl_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire adc_ctrl_pkg::reg_req_s reg_req,
  input wire logic [7:0] rd_data,
  input wire adc_ctrl_pkg::sleep_mode_e sleep_mode,
  input wire logic sample_strobe,
  input wire logic clk_request,
  input wire logic irq_result_ready,
  input wire logic irq_window_compare,
  input wire logic irq,
  input wire logic [7:0] irq_vector
);
  import adc_ctrl_pkg::*;
  logic clr_rr;
  assign clr_rr = reg_req.wr && (reg_req.addr == 5'h0A
    || (reg_req.addr == 5'h0B && reg_req.wdata[0]));
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  irq_or_a: assert property (irq == (irq_result_ready | irq_window_compare))
    else $error("irq differs from source requests");
  vec_rr_a: assert property (irq_result_ready |-> irq_vector == 8'h00)
    else $error("result vector wrong");
  vec_wc_a: assert property (irq_window_compare && !irq_result_ready
    |-> irq_vector == 8'h02) else $error("window vector wrong");
  vec_hold_a: assert property (!irq && !$past(irq) |-> $stable(irq_vector))
    else $error("vector moved without request");
  rr_hold_a: assert property ($fell(irq_result_ready)
    |-> $past(clr_rr) || $past(clr_rr, 2)) else $error("request dropped");
  strobe_req_a: assert property (sample_strobe |-> clk_request)
    else $error("sampling without clock request");
  strobe_once_a: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("conversion restarted");
  pd_start_a: assert property ((sleep_mode == SLEEP_POWER_DOWN) [*3]
    |-> !sample_strobe) else $error("sampling in power-down");
  rd_idle_a: assert property (!$past(reg_req.rd) |-> rd_data == 8'h00)
    else $error("read data without read");
  cover property (irq_result_ready && irq_window_compare);
  cover property (sleep_mode == SLEEP_STANDBY && sample_strobe);
  cover property (sleep_mode == SLEEP_POWER_DOWN && clk_request);
endmodule : adc_ctrl_chk
bind adc_trigger_irq_sleep_ctrl adc_ctrl_chk u_chk (.clk_sys, .arst_n,
  .reg_req, .rd_data, .sleep_mode, .sample_strobe, .clk_request,
  .irq_result_ready, .irq_window_compare, .irq, .irq_vector);

//--- test_adc_trigger_irq_sleep_ctrl.sv
`timescale 1ns/1ps
module test_adc_trigger_irq_sleep_ctrl;
  import adc_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  reg_req_s reg_req = '0;
  sleep_mode_e sleep_mode = SLEEP_ACTIVE;
  logic start_event, sample_strobe, clk_request, irq, irq_rr, irq_wc;
  logic [9:0] sample_value;
  logic [7:0] rd_data, irq_vector, d;
  int n_irq, n_mismatch = 0, n_checks = 0, cyc = 0, n, base, k;
  always #4 clk_sys = ~clk_sys;
  adc_trigger_irq_sleep_ctrl uut (.clk_sys, .arst_n, .reg_req, .rd_data,
    .sleep_mode, .dbg_halt(1'b0), .start_event, .sample_value,
    .sample_strobe, .clk_request, .irq_result_ready(irq_rr),
    .irq_window_compare(irq_wc), .irq, .irq_vector);
  adc_evt_src u_src (.clk_sys, .irq, .start_event, .sample_value, .n_irq);
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 d = rd_data;
    chk(d, e);
  endtask : rc
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(irq, 1'b1);
  endtask : wait_irq
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic sm(input sleep_mode_e m);
    @(posedge clk_sys);
    sleep_mode <= m;
  endtask : sm
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rc(5'h0A, 8'h00);
    wr(5'h0D, 8'hA5);
    rc(5'h0D, 8'hA5);
    wr(5'h00, 8'hFF);
    rc(5'h00, 8'h87);
    wr(5'h07, 8'hFF);
    rc(5'h07, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_soft;
    wr(5'h04, 8'h02);
    wr(5'h15, 8'h01);
    wr(5'h0A, 8'h01);
    wr(5'h00, 8'h01);
    wr(5'h08, 8'h01);
    wait_irq();
    chk(irq_vector, 8'h00);
    rc(5'h0B, 8'h03);
    rc(5'h08, 8'h00);
    rc(5'h10, 8'hFF);
    rc(5'h11, 8'h03);
    wr(5'h0B, 8'h01);
    rc(5'h0B, 8'h02);
    chk(irq, 1'b0);
    wr(5'h0A, 8'h02);
    idle(3);
    chk(irq_vector, 8'h02);
    wr(5'h0B, 8'h00);
    rc(5'h0B, 8'h02);
    wr(5'h0B, 8'h02);
    idle(3);
    chk(irq, 1'b0);
    wr(5'h0A, 8'h01);
    $display("t_soft done");
  endtask : t_soft
  task automatic t_delay;
    int dly[7] = '{0, 16, 32, 64, 128, 256, 0};
    for (int c = 0; c < 7; c++) begin
      wr(5'h00, 8'h00);
      wr(5'h03, {c[2:0], 5'h00});
      wr(5'h00, 8'h01);
      wr(5'h08, 8'h01);
      wait_irq();
      if (c == 0) base = n;
      chk(16'(n - base), 16'(2 * dly[c]));
      wr(5'h0B, 8'h03);
    end
    $display("t_delay done");
  endtask : t_delay
  task automatic t_event;
    u_src.pulse();
    idle(60);
    rc(5'h0B, 8'h00);
    wr(5'h09, 8'h01);
    u_src.pulse();
    u_src.pulse();
    wait_irq();
    wr(5'h0B, 8'h03);
    idle(60);
    rc(5'h0B, 8'h00);
    $display("t_event done");
  endtask : t_event
  task automatic t_sleep;
    sm(SLEEP_STANDBY);
    u_src.pulse();
    idle(60);
    chk(clk_request, 1'b0);
    rc(5'h0B, 8'h00);
    wr(5'h03, 8'h20);
    wr(5'h00, 8'h81);
    k = n_irq;
    u_src.pulse();
    wait_irq();
    chk(clk_request, 1'b0);
    wr(5'h0B, 8'h03);
    chk(16'(n_irq - k), 16'h0001);
    sm(SLEEP_ACTIVE);
    wr(5'h03, 8'h00);
    wr(5'h08, 8'h01);
    idle(8);
    sm(SLEEP_POWER_DOWN);
    idle(100);
    chk(irq, 1'b0);
    sm(SLEEP_ACTIVE);
    wait_irq();
    rc(5'h18, 8'h01);
    chk(d[0], 1'b1);
    wr(5'h0B, 8'h03);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic t_free;
    wr(5'h0A, 8'h00);
    wr(5'h00, 8'h03);
    wr(5'h08, 8'h01);
    k = 0;
    repeat (200) begin
      @(posedge clk_sys);
      #1 k += sample_strobe;
    end
    wr(5'h00, 8'h00);
    chk(16'(k > 5), 16'h0001);
    $display("t_free done");
  endtask : t_free
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_soft();
    t_delay();
    t_event();
    t_sleep();
    t_free();
    test_done();
  end
endmodule : test_adc_trigger_irq_sleep_ctrl
